// [csb_pkg.sv]
// Package for the processor sideband block: types and constants
package csb_pkg;

  // ==========================================================
  // Timing and widths
  // ==========================================================
  localparam int CSB_CLK_PERIOD_NS = 10;
  localparam int CSB_RELEASE_CLOCKS = 2;   // Bus outputs released within this many clocks of hard reset
  localparam int CSB_SYNC_STAGES = 3;

  // Bit positions in the synchronised asynchronous input vector
  localparam int CSB_IN_STOP = 0;
  localparam int CSB_IN_PROBE = 1;
  localparam int CSB_IN_IGN = 2;
  localparam int CSB_IN_SINIT = 3;
  localparam int CSB_IN_LINT0 = 4;
  localparam int CSB_IN_LINT1 = 5;
  localparam int CSB_IN_BUS_INITIALISE_N = 6;
  localparam int CSB_IN_WIDTH = 7;

  // Reset value of the local interrupt controller enable
  localparam logic CSB_LIC_EN_RESET = 1'b1;

  // ==========================================================
  // Carriers
  // ==========================================================
  // Core-side event and status inputs (same clock)
  typedef struct packed {
    logic fp_error;          // Unmasked floating-point error pending
    logic internal_error;    // Internal error pulse
    logic fp_instr;          // Noncontrol FP instruction issued
    logic snoop_stall_req;   // Device wants a snoop stall
    logic snoop_hit;         // Snoop hit result
    logic snoop_hit_mod;     // Snoop hit-modified result
    logic snoop_result_valid; // Result phase pulse
    logic lock_seq;          // Atomic sequence in progress
  } csb_core_s;

  // Core-side actions out
  typedef struct packed {
    logic fp_exception;      // Raise FP exception
    logic soft_init;         // Integer-register reset, restart at reset vector
    logic run_self_test;     // Self-test requested at reset release
    logic maskable_interrupt_request;
    logic nonmaskable_interrupt;
    logic local_int0;        // Local-interrupt function of pin zero
    logic local_int1;
    logic transaction_a_req;      // Issue transaction_a on the bus
  } csb_act_s;

endpackage

// [csb_sync.sv]
// Three-stage synchroniser with agreement filter for asynchronous pins
`timescale 1ns/1ps
module csb_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic i_clk,              // Bus clock
  input wire logic i_reset_n,          // Async reset, active low
  input wire logic [WIDTH-1:0] i_async, // Raw pin levels
  output logic [WIDTH-1:0] o_level     // Filtered level
);

  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;
  logic [WIDTH-1:0] level;
  logic [WIDTH-1:0] next_level;

  // ==========================================================
  // Filter
  // ==========================================================
  // Change accepted only where stages two and three agree
  always_comb begin
    next_level = level;
    for (int k = 0; k < WIDTH; k++) begin
      if (s2[k] == s3[k]) begin
        next_level[k] = s3[k];
      end
    end
  end

  // Stage one feeds only stage two
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s1 <= INIT;
      s2 <= INIT;
      s3 <= INIT;
      level <= INIT;
    end else begin
      s1 <= i_async;
      s2 <= s1;
      s3 <= s2;
      level <= next_level;
    end
  end

  assign o_level = level;

endmodule

// [csb_sideband.sv]
// Processor sideband logic: error/break, snoop stall, lock, init and local interrupts
//
// Behaviour
// - Stop-clock inactive: shared output shows an unmasked floating-point error.
// - Stop-clock active: shared output shows a pending break event.
// - Break indication holds until stop-clock request deasserts.
// - Probe request during stop-clock also raises a pending break event.
// - Snoop stall drives hit and hit-modified together; repeated pair extends.
// - Internal-error output sticks until hard reset, bus-initialise or soft-initialise.
// - Internal error not already latched is accompanied by a transaction_a-type bus transaction.
// - Ignore input continues FP; otherwise exception on instruction after an error.
// - Ignore input has no effect while numeric-error-enable is set.
// - Soft-init resets integer state only, restarting at reset vector.
// - Snoop servicing continues during soft-initialise.
// - Soft-init active at hard reset release starts self-test.
// - Controller disabled: pin zero maskable, pin one nonmaskable interrupt.
// - Local interrupt controller is enabled after reset.
// - Bus-lock held from first transaction start to last transaction end.
// - Bus outputs released within two clocks of observed hard reset.
`timescale 1ns/1ps
module csb_sideband (
  input wire logic i_clk,                          // Bus clock, 100 MHz
  input wire logic i_reset_n,                      // Hard reset, async, active low
  input wire logic i_stop_clock_request_n,         // Stop-clock request pin
  input wire logic i_probe_request_n,              // Debug probe request pin
  input wire logic i_ignore_numeric_error_n,       // Ignore numeric error pin
  input wire logic i_soft_init_n,                  // Soft-initialise pin
  input wire logic i_bus_initialise_n,             // Bus-initialise pin
  input wire logic [1:0] i_local_interrupt_pins,   // Local interrupt pins, active high
  input wire logic i_snoop_hit_n,                  // Snoop hit pin, input side
  input wire logic i_snoop_hit_modified_n,         // Hit-modified pin, input side
  input wire logic i_lock_n,                       // Bus-lock pin, input side
  input wire logic i_numeric_error_enable,         // Bit of control_register_zero
  input wire logic i_local_int_ctrl_disable,       // Software disables local controller
  input wire csb_pkg::csb_core_s i_core,           // Core events
  output csb_pkg::csb_act_s o_act,                 // Core actions
  output logic o_fp_error_break_event_n,           // Shared error/break output
  output logic o_internal_error_n,                 // Sticky internal error output
  output logic o_snoop_hit_n,                      // Snoop hit drive level
  output logic o_snoop_hit_modified_n,             // Hit-modified drive level
  output logic o_snoop_oe,                         // Enable for both snoop pins
  output logic o_lock_n,                           // Bus-lock drive level
  output logic o_lock_oe,                          // Bus-lock enable
  output logic o_stalled                           // Other agent is stalling snoop
);
  import csb_pkg::*;

  // Edges after reset release until the synchroniser outputs are valid again
  localparam logic [2:0] SETTLE_LAST = 3'(CSB_SYNC_STAGES + 1);

  // ==========================================================
  // Input synchronisation
  // ==========================================================
  logic [CSB_IN_WIDTH-1:0] raw;
  logic [CSB_IN_WIDTH-1:0] syn;

  // Active-low pins inverted so syn is active high
  always_comb begin
    raw = '0;
    raw[CSB_IN_STOP] = ~i_stop_clock_request_n;
    raw[CSB_IN_PROBE] = ~i_probe_request_n;
    raw[CSB_IN_IGN] = ~i_ignore_numeric_error_n;
    raw[CSB_IN_SINIT] = ~i_soft_init_n;
    raw[CSB_IN_LINT0] = i_local_interrupt_pins[0];
    raw[CSB_IN_LINT1] = i_local_interrupt_pins[1];
    raw[CSB_IN_BUS_INITIALISE_N] = ~i_bus_initialise_n;
  end

  csb_sync #(
    .WIDTH(CSB_IN_WIDTH),
    .INIT('0)
  ) u_sync (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_async(raw),
    .o_level(syn)
  );

  logic stop_act;
  logic probe_act;
  logic ign_act;
  logic sinit_act;
  logic bus_initialise_n_act;
  assign stop_act = syn[CSB_IN_STOP];
  assign probe_act = syn[CSB_IN_PROBE];
  assign ign_act = syn[CSB_IN_IGN];
  assign sinit_act = syn[CSB_IN_SINIT];
  assign bus_initialise_n_act = syn[CSB_IN_BUS_INITIALISE_N];

  // ==========================================================
  // Error and break state
  // ==========================================================
  logic break_pend;
  logic next_break_pend;
  logic internal_error_n;
  logic next_internal_error_n;
  logic fp_out;
  logic next_fp_out;
  logic probe_prev;
  logic next_probe_prev;
  logic transaction_a;
  logic next_transaction_a;
  logic fp_exc;
  logic next_fp_exc;

  always_comb begin
    next_probe_prev = probe_act;
    next_break_pend = break_pend;
    if (stop_act && (i_core.fp_error || (probe_act && !probe_prev))) begin
      next_break_pend = 1'b1;
    end
    if (!stop_act) begin
      next_break_pend = 1'b0;
    end
    next_fp_out = stop_act ? next_break_pend : i_core.fp_error;
    // sticky until reset, bus-init or soft-init; a new error wins
    next_internal_error_n = internal_error_n;
    if (bus_initialise_n_act || sinit_act) begin
      next_internal_error_n = 1'b0;
    end
    if (i_core.internal_error) begin
      next_internal_error_n = 1'b1;
    end
    // one transaction_a request per new internal error
    next_transaction_a = i_core.internal_error && !internal_error_n;
    // exception unless ignore; ignore masked by enable bit
    next_fp_exc = i_core.fp_instr && i_core.fp_error && (i_numeric_error_enable || !ign_act);
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      break_pend <= 1'b0;
      internal_error_n <= 1'b0;
      fp_out <= 1'b0;
      probe_prev <= 1'b0;
      transaction_a <= 1'b0;
      fp_exc <= 1'b0;
    end else begin
      break_pend <= next_break_pend;
      internal_error_n <= next_internal_error_n;
      fp_out <= next_fp_out;
      probe_prev <= next_probe_prev;
      transaction_a <= next_transaction_a;
      fp_exc <= next_fp_exc;
    end
  end

  assign o_fp_error_break_event_n = ~fp_out;
  assign o_internal_error_n = ~internal_error_n;

  // ==========================================================
  // Init, self-test and local interrupts
  // ==========================================================
  logic [2:0] settle;
  logic [2:0] next_settle;
  logic rst_seen;
  logic next_rst_seen;
  logic bist;
  logic next_bist;
  logic sinit_q;
  logic next_sinit_q;
  logic lic_en;
  logic next_lic_en;
  logic [1:0] lint_q;
  logic [1:0] next_lint_q;

  always_comb begin
    // Syncs restart from zero, so pin levels are trusted only once refilled
    next_settle = (settle == SETTLE_LAST) ? settle : settle + 3'h1;
    next_rst_seen = (settle == SETTLE_LAST);
    // soft-init level held through release, judged once syncs refill
    next_bist = (settle == SETTLE_LAST) && !rst_seen && sinit_act;
    // integer reset pulse on soft-init rise after reset
    next_sinit_q = sinit_act;
    // controller enabled after reset until software disables
    next_lic_en = ~i_local_int_ctrl_disable;
    next_lint_q = {syn[CSB_IN_LINT1], syn[CSB_IN_LINT0]};
  end

  // Release edge is caught by the clock, not by the reset itself
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      settle <= 3'h0;
      rst_seen <= 1'b0;
      bist <= 1'b0;
      sinit_q <= 1'b0;
      lic_en <= CSB_LIC_EN_RESET;
      lint_q <= 2'h0;
    end else begin
      settle <= next_settle;
      rst_seen <= next_rst_seen;
      bist <= next_bist;
      sinit_q <= next_sinit_q;
      lic_en <= next_lic_en;
      lint_q <= next_lint_q;
    end
  end

  // pin roles follow the controller enable
  always_comb begin
    o_act = '0;
    o_act.fp_exception = fp_exc;
    o_act.soft_init = sinit_act && !sinit_q && rst_seen;
    o_act.run_self_test = bist;
    o_act.transaction_a_req = transaction_a;
    o_act.maskable_interrupt_request = !lic_en && lint_q[0];
    o_act.nonmaskable_interrupt = !lic_en && lint_q[1];
    o_act.local_int0 = lic_en && lint_q[0];
    o_act.local_int1 = lic_en && lint_q[1];
  end

  // ==========================================================
  // Snoop stall and bus lock
  // ==========================================================
  logic snoop_oe;
  logic next_snoop_oe;
  logic hit;
  logic next_hit;
  logic snoop_hit_modified_n;
  logic next_snoop_hit_modified_n;
  logic lock_oe;
  logic next_lock_oe;

  // Snoop drive is independent of soft-init, so snooping carries on
  always_comb begin
    next_snoop_oe = 1'b0;
    next_hit = 1'b0;
    next_snoop_hit_modified_n = 1'b0;
    if (i_core.snoop_result_valid) begin
      next_snoop_oe = 1'b1;
      next_hit = i_core.snoop_stall_req || i_core.snoop_hit;
      next_snoop_hit_modified_n = i_core.snoop_stall_req || i_core.snoop_hit_mod;
    end
    // lock held for the whole atomic sequence
    next_lock_oe = i_core.lock_seq;
  end

  // async reset releases all bus drive at once
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      snoop_oe <= 1'b0;
      hit <= 1'b0;
      snoop_hit_modified_n <= 1'b0;
      lock_oe <= 1'b0;
    end else begin
      snoop_oe <= next_snoop_oe;
      hit <= next_hit;
      snoop_hit_modified_n <= next_snoop_hit_modified_n;
      lock_oe <= next_lock_oe;
    end
  end

  assign o_snoop_oe = snoop_oe;
  assign o_snoop_hit_n = ~hit;
  assign o_snoop_hit_modified_n = ~snoop_hit_modified_n;
  assign o_lock_oe = lock_oe;
  assign o_lock_n = ~lock_oe;
  // other agent stalls when both pins low
  assign o_stalled = !snoop_oe && !i_snoop_hit_n && !i_snoop_hit_modified_n;

endmodule

// [csb_sideband_properties.sv]
// Concurrent checks on the sideband block ports
`timescale 1ns/1ps
module csb_sideband_properties (
  input wire logic i_clk, // Bus clock
  input wire logic i_reset_n, // Hard reset
  input wire logic i_stop_clock_request_n, // Stop pin
  input wire logic i_probe_request_n, // Probe pin
  input wire logic i_soft_init_n, // Soft-init pin
  input wire logic i_bus_initialise_n, // Bus-init pin
  input wire logic i_numeric_error_enable, // Control bit
  input wire csb_pkg::csb_core_s i_core, // Core events
  input wire csb_pkg::csb_act_s o_act, // Core actions
  input wire logic o_fp_error_break_event_n, // Error/break
  input wire logic o_internal_error_n, // Internal error
  input wire logic o_snoop_hit_n, // Hit level
  input wire logic o_snoop_hit_modified_n, // Snoop_hit_modified_n level
  input wire logic o_snoop_oe, // Snoop enable
  input wire logic o_lock_n, // Lock level
  input wire logic o_lock_oe // Lock enable
);
  import csb_pkg::*;
  logic [5:0] h_stop;
  logic [5:0] h_inits;
  logic [5:0] next_h_stop;
  logic [5:0] next_h_inits;
  // ==========================================================
  // Pin histories
  // ==========================================================
  // Mixed reset pattern, so no pin looks settled before the syncs fill
  always_comb begin
    next_h_stop = {h_stop[4:0], i_stop_clock_request_n};
    next_h_inits = {h_inits[4:0], i_soft_init_n & i_bus_initialise_n};
  end
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      h_stop <= 6'h2a;
      h_inits <= 6'h2a;
    end else begin
      h_stop <= next_h_stop;
      h_inits <= next_h_inits;
    end
  end
  // ==========================================================
  // Properties
  // ==========================================================
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  sequence s_err_raise;
    !o_internal_error_n && o_act.transaction_a_req;
  endsequence
  sequence s_stall_drive;
    o_snoop_oe && !o_snoop_hit_n && !o_snoop_hit_modified_n;
  endsequence
  fp_run_a: assert property (&h_stop |=> o_fp_error_break_event_n == !$past(i_core.fp_error))
    else $error("error output does not follow fp error");
  break_hold_a: assert property (~|h_stop && !o_fp_error_break_event_n |=> !o_fp_error_break_event_n)
    else $error("break indication dropped while stopped");
  probe_break_a: assert property (~|h_stop && $fell(i_probe_request_n) |-> ##[1:7] !o_fp_error_break_event_n)
    else $error("probe request gave no break event");
  internal_error_n_set_a: assert property (i_core.internal_error |=> s_err_raise)
    else $error("internal error not raised with transaction_a");
  internal_error_n_hold_a: assert property (!o_internal_error_n && &h_inits |=> !o_internal_error_n)
    else $error("internal error cleared without cause");
  snoop_pair_a: assert property (i_core.snoop_result_valid && i_core.snoop_stall_req |=> s_stall_drive)
    else $error("stall not driven on both snoop pins");
  fp_exc_a: assert property (i_core.fp_instr && i_core.fp_error && i_numeric_error_enable |=> o_act.fp_exception)
    else $error("fp exception missing with enable set");
  lock_hold_a: assert property (i_core.lock_seq |=> o_lock_oe && !o_lock_n)
    else $error("bus lock not held during sequence");
endmodule
bind csb_sideband csb_sideband_properties u_props (.i_clk, .i_reset_n, .i_stop_clock_request_n,
  .i_probe_request_n, .i_soft_init_n, .i_bus_initialise_n, .i_numeric_error_enable, .i_core, .o_act,
  .o_fp_error_break_event_n, .o_internal_error_n, .o_snoop_hit_n, .o_snoop_hit_modified_n,
  .o_snoop_oe, .o_lock_n, .o_lock_oe);

// [csb_chipset_model.sv]
// Chipset-side model: stop-clock control, wake on break, snoop wires
`timescale 1ns/1ps
module csb_chipset_model (
  input wire logic i_clk, // Bus clock
  input wire logic i_reset_n, // Hard reset
  input wire logic i_want_stop, // Bench asks for stop-clock
  input wire logic i_slow, // Wake late, not at once
  input wire logic i_stall, // Model stalls the snoop phase
  input wire logic i_fp_n, // Device error/break output
  input wire logic i_hit_n, // Device hit level
  input wire logic i_snoop_hit_modified_n_n, // Device hit-modified level
  input wire logic i_oe, // Device snoop enable
  output logic o_stop_n, // Stop-clock pin
  output logic o_hit_n, // Hit wire
  output logic o_snoop_hit_modified_n_n // Hit-modified wire
);
  logic woke;
  logic [3:0] dly;
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n || !i_want_stop) begin
      woke <= 1'b0;
      dly <= 4'h0;
    end else if (!i_fp_n && !woke) begin
      dly <= dly + 4'h1;
      woke <= !i_slow || dly == 4'h9;
    end
  end
  assign o_stop_n = !(i_want_stop && !woke);
  assign o_hit_n = !(i_stall || (i_oe && !i_hit_n));
  assign o_snoop_hit_modified_n_n = !(i_stall || (i_oe && !i_snoop_hit_modified_n_n));
endmodule

// [tb_top.sv]
// Self-checking bench for the sideband block
`timescale 1ns/1ps
module tb_top;
  import csb_pkg::*;
  logic clk, rst_n, probe_n, ign_n, sinit_n, bus_initialise_n_n, ne, lic_dis, want_stop, slow, stall;
  logic stop_n, hit_n, snoop_hit_modified_n_n, fp_n, internal_error_n_n, d_hit_n, d_snoop_hit_modified_n_n, oe, d_lock_n, lock_oe, stalled;
  logic [1:0] lint;
  csb_core_s core;
  csb_act_s act;
  logic [6:0] res;
  logic [6:0] q[$];
  int fail_count = 0;
  int compares = 0;
  // ==========================================================
  // Clock, design and partner
  // ==========================================================
  always #(CSB_CLK_PERIOD_NS / 2) clk = ~clk;
  csb_sideband DUT (.i_clk(clk), .i_reset_n(rst_n), .i_stop_clock_request_n(stop_n), .i_probe_request_n(probe_n),
    .i_ignore_numeric_error_n(ign_n), .i_soft_init_n(sinit_n), .i_bus_initialise_n(bus_initialise_n_n),
    .i_local_interrupt_pins(lint), .i_snoop_hit_n(hit_n), .i_snoop_hit_modified_n(snoop_hit_modified_n_n),
    .i_lock_n(!(lock_oe && !d_lock_n)), .i_numeric_error_enable(ne), .i_local_int_ctrl_disable(lic_dis),
    .i_core(core), .o_act(act), .o_fp_error_break_event_n(fp_n), .o_internal_error_n(internal_error_n_n),
    .o_snoop_hit_n(d_hit_n), .o_snoop_hit_modified_n(d_snoop_hit_modified_n_n), .o_snoop_oe(oe), .o_lock_n(d_lock_n),
    .o_lock_oe(lock_oe), .o_stalled(stalled));
  csb_chipset_model u_chipset (.i_clk(clk), .i_reset_n(rst_n), .i_want_stop(want_stop), .i_slow(slow),
    .i_stall(stall), .i_fp_n(fp_n), .i_hit_n(d_hit_n), .i_snoop_hit_modified_n_n(d_snoop_hit_modified_n_n), .i_oe(oe), .o_stop_n(stop_n),
    .o_hit_n(hit_n), .o_snoop_hit_modified_n_n(snoop_hit_modified_n_n));
  // Event outputs as one word; snoop levels only count while driven
  assign res = {act.fp_exception, act.soft_init, act.run_self_test, act.transaction_a_req, oe,
    oe ? {d_hit_n, d_snoop_hit_modified_n_n} : 2'b11};
  // ==========================================================
  // Helpers
  // ==========================================================
  task automatic chk(input logic [6:0] got, input logic [6:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Bounded wait, so a dead output cannot hang the run
  task automatic wait_lvl(ref logic sig, input logic val);
    for (int n = 0; n < 50 && sig !== val; n++) cyc(1);
  endtask
  task automatic wrap_up();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Any event output takes the oldest note; none left means unexpected
  always @(negedge clk) begin
    if (rst_n && (|res[6:2]) !== 1'b0) chk(res, q.size() > 0 ? q.pop_front() : 7'h00);
  end
  initial begin
    #50us;
    fail_count++;
    $display("ERROR %0t: watchdog expired", $time);
    wrap_up();
  end
  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    {clk, rst_n, ne, lic_dis, want_stop, slow, stall, lint} = '0;
    {probe_n, ign_n, sinit_n, bus_initialise_n_n} = 4'hf;
    core = '0;
    void'($urandom(47397));
    cyc(5);
    chk({fp_n, internal_error_n_n, oe, lock_oe, |act}, 7'h18);
    cyc(5);
    rst_n = 1;
    lint = 2'b11;
    cyc(8);
    chk({act.maskable_interrupt_request, act.nonmaskable_interrupt, act.local_int0, act.local_int1}, 7'h03);
    lic_dis = 1;
    lint = 2'($urandom);
    cyc(8);
    chk({act.maskable_interrupt_request, act.nonmaskable_interrupt}, {lint[0], lint[1]});
    lic_dis = 0;
    // Error cleared by soft-init, with back-to-back stalls meanwhile
    core.internal_error = 1;
    q.push_back(7'h0b);
    cyc(1);
    core.internal_error = 0;
    chk(internal_error_n_n, 1'b0);
    q.push_back(7'h23);
    sinit_n = 0;
    cyc(6);
    {core.snoop_result_valid, core.snoop_stall_req} = 2'b11;
    q.push_back(7'h04);
    q.push_back(7'h04);
    cyc(2);
    // Plain snoop result with random hit levels, still during soft-init
    core.snoop_stall_req = 0;
    {core.snoop_hit, core.snoop_hit_mod} = 2'($urandom);
    q.push_back({5'h01, !core.snoop_hit, !core.snoop_hit_mod});
    cyc(1);
    core.snoop_result_valid = 0;
    chk(internal_error_n_n, 1'b1);
    sinit_n = 1;
    // Let soft-init drain so only bus-init can clear the next error
    cyc(5);
    core.internal_error = 1;
    q.push_back(7'h0b);
    cyc(1);
    core.internal_error = 0;
    chk(internal_error_n_n, 1'b0);
    bus_initialise_n_n = 0;
    cyc(8);
    chk(internal_error_n_n, 1'b1);
    bus_initialise_n_n = 1;
    stall = 1;
    cyc(1);
    chk(stalled, 1'b1);
    stall = 0;
    // Every enable and ignore combination
    // ignore level settles well before each instruction
    core.fp_error = 1;
    for (int k = 0; k < 4; k++) begin
      ne = k[0];
      ign_n = k[1];
      cyc(8);
      if (ne || ign_n) q.push_back(7'h43);
      core.fp_instr = 1;
      cyc(1);
      core.fp_instr = 0;
    end
    core.fp_error = 0;
    // Break from fp error, then from probe, with random wake speed
    for (int k = 0; k < 2; k++) begin
      slow = 1'($urandom);
      want_stop = 1;
      cyc(8);
      if (k == 1) probe_n = 0;
      else core.fp_error = 1;
      wait_lvl(fp_n, 1'b0);
      probe_n = 1;
      core.fp_error = 0;
      wait_lvl(stop_n, 1'b1);
      chk(fp_n, 1'b0);
      cyc(8);
      chk(fp_n, 1'b1);
      want_stop = 0;
      // Model must see the drop, or its wake flag carries into the next round
      cyc(2);
    end
    core.lock_seq = 1;
    cyc($urandom_range(2, 6));
    chk({lock_oe, d_lock_n}, 7'h02);
    core.lock_seq = 0;
    cyc(1);
    chk({lock_oe, d_lock_n}, 7'h01);
    // Soft-init held across a hard reset release
    sinit_n = 0;
    q.push_back(7'h23);
    cyc(6);
    rst_n = 0;
    cyc(6);
    q.push_back(7'h13);
    rst_n = 1;
    cyc(6);
    sinit_n = 1;
    cyc(10);
    chk(7'(q.size()), 7'h00);
    wrap_up();
  end
endmodule
